// ---- rtl/bls_boot_seq.sv ----
// Boot sequencer: switch watch, tape rewind, Break, paced character stream, checksum
// Notes on behaviour
// RULE1: After power-up sample the switch; if closed wait one second then boot.
// RULE2: In idle an open-then-close of the switch starts a one-second wait then boot.
// RULE3: Boot first positions drive 0 to block 0, then sends Break.
// RULE4: After Break, fetch characters from tape and send each, with a gap after each.
// RULE5: After a digit 0 to 7 the gap is one character time at 9600 baud.
// RULE6: After any other character the gap covers fifteen echoed characters.
// RULE7: Return to idle right after sending the terminating character 0x67.
// RULE8: Host serial port runs at 9600, 19200 or 38400 baud during boot.
// RULE9: Idle with a cartridge present, the Continue byte 0x10 has been sent.
// RULE10: Checksum is a 16-bit sum of little-endian byte pairs, end-around carry.
// RULE11: Switch activity is ignored while booting and honoured again in idle.
// RULE12: Break holds the transmit line at space for longer than one frame.
`include "bls_defs.svh"
`default_nettype none
module bls_boot_seq #(
  parameter int unsigned SETTLE_CYC = `BLS_SETTLE_CYC,
  parameter int unsigned BIT_CYC    = `BLS_BIT_CYC
) (
  // Clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RST_N,
  // Boot switch, low while closed
  input  wire logic              BOOT_SWITCH_PIN,
  // Serial line
  input  wire logic [1:0]        BAUD_SEL,
  output logic                   TX_LINE,
  // Tape drive 0
  input  wire logic              CART_PRESENT,
  output logic                   TAPE_SEEK_REQ,
  input  wire logic              TAPE_SEEK_DONE,
  output logic                   TAPE_CHAR_REQ,
  input  wire bls_pkg::bls_char_t TAPE_CHAR,
  // Status
  output logic                   BOOT_ACTIVE,
  // Packet checksum
  input  wire bls_pkg::bls_ck_t  CK_IN,
  output logic [15:0]            CK_SUM
);
  import bls_pkg::*;

  localparam logic [31:0] SETTLE = 32'(SETTLE_CYC);
  localparam logic [31:0] BIT_T  = 32'(BIT_CYC);
  localparam logic [31:0] GAP_DIG  = 32'(`BLS_FRAME_BITS) * BIT_T;
  localparam logic [31:0] GAP_CTRL = 32'(`BLS_ECHO_CHARS) * GAP_DIG;

  bls_state_t  state_reg;
  logic [31:0] timer_reg;
  logic [7:0]  char_reg;
  logic        saw_open_reg;
  logic        cont_sent_reg;
  logic [9:0]  tx_shift_reg;
  logic [3:0]  tx_bits_reg;
  logic [31:0] tx_cnt_reg;
  logic        tx_busy_reg;
  logic        ck_hi_reg;
  logic        send_started_reg;
  logic [31:0] bit_cyc;
  logic [31:0] brk_cyc;
  logic        sw_closed;
  logic        is_digit;
  logic        send_go;
  logic        cont_go;
  logic        tx_go;
  logic [7:0]  tx_data;

  function automatic logic [15:0] ck_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction : ck_add

  assign sw_closed = ~BOOT_SWITCH_PIN;
  assign is_digit  = (char_reg >= `BLS_DIGIT_LO) && (char_reg <= `BLS_DIGIT_HI);
  // Code 3 on the rate select is taken as 38400
  assign bit_cyc   = BIT_T >> ((BAUD_SEL == 2'h3) ? 2'h2 : BAUD_SEL);
  assign brk_cyc   = 32'(`BLS_BREAK_FRAMES * `BLS_FRAME_BITS) * bit_cyc;
  assign send_go   = (state_reg == ST_SEND) && !tx_busy_reg;
  assign cont_go   = (state_reg == ST_IDLE) && CART_PRESENT && !cont_sent_reg && !tx_busy_reg;
  assign tx_go     = send_go || cont_go;
  assign tx_data   = send_go ? char_reg : `BLS_CHAR_CONT;

  // Sequencer, its timer and the tape handshakes
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg     <= ST_PWRUP;
      timer_reg     <= 32'h0000_0000;
      char_reg      <= 8'h00;
      TAPE_SEEK_REQ <= 1'b0;
      TAPE_CHAR_REQ <= 1'b0;
    end else begin
      case (state_reg)
        ST_PWRUP: begin
          timer_reg <= SETTLE;
          state_reg <= sw_closed ? ST_WAIT : ST_IDLE; // RULE1
        end
        ST_IDLE: begin
          if (saw_open_reg && sw_closed) begin
            timer_reg <= SETTLE;
            state_reg <= ST_WAIT; // RULE2
          end
        end
        ST_WAIT: begin
          if (timer_reg == 32'h0000_0000) begin
            state_reg     <= ST_SEEK;
            TAPE_SEEK_REQ <= 1'b1; // RULE3
          end else begin
            timer_reg <= timer_reg - 32'h0000_0001;
          end
        end
        ST_SEEK: begin
          if (TAPE_SEEK_DONE) begin
            TAPE_SEEK_REQ <= 1'b0;
          end
          if (!TAPE_SEEK_REQ && !tx_busy_reg) begin
            timer_reg <= brk_cyc;
            state_reg <= ST_BRK; // RULE3
          end
        end
        ST_BRK: begin
          if (timer_reg == 32'h0000_0000) begin
            state_reg     <= ST_FETCH;
            TAPE_CHAR_REQ <= 1'b1; // RULE4
          end else begin
            timer_reg <= timer_reg - 32'h0000_0001;
          end
        end
        ST_FETCH: begin
          if (TAPE_CHAR.valid) begin
            char_reg      <= TAPE_CHAR.data;
            TAPE_CHAR_REQ <= 1'b0;
            state_reg     <= ST_SEND; // RULE4
          end
        end
        ST_SEND: begin
          // Gap starts once the frame is fully on the line; none after the terminator
          if (send_started_reg && !tx_busy_reg) begin
            if (char_reg == `BLS_CHAR_TERM) begin
              state_reg <= ST_IDLE; // RULE7
            end else begin
              timer_reg <= is_digit ? GAP_DIG : GAP_CTRL; // RULE5 RULE6
              state_reg <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          if (timer_reg != 32'h0000_0000) begin
            timer_reg <= timer_reg - 32'h0000_0001;
          end else begin
            state_reg     <= ST_FETCH;
            TAPE_CHAR_REQ <= 1'b1; // RULE4
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Send holds a flag for one pass through the frame
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      send_started_reg <= 1'b0;
    end else begin
      send_started_reg <= (state_reg == ST_SEND) && (send_go || send_started_reg);
    end
  end

  // Switch edge memory, only armed in idle
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      saw_open_reg <= 1'b0;
    end else if (state_reg != ST_IDLE) begin
      saw_open_reg <= 1'b0; // RULE11
    end else if (!sw_closed) begin
      saw_open_reg <= 1'b1; // RULE2
    end else if (saw_open_reg) begin
      saw_open_reg <= 1'b0;
    end
  end

  // Continue byte once per idle stay with a cartridge
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cont_sent_reg <= 1'b0;
    end else if (cont_go) begin
      cont_sent_reg <= 1'b1; // RULE9
    end else if (!CART_PRESENT || (state_reg != ST_IDLE)) begin
      cont_sent_reg <= 1'b0;
    end
  end

  // Transmit serializer, 8N1, lsb first
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_shift_reg <= 10'h3FF;
      tx_bits_reg  <= 4'h0;
      tx_cnt_reg   <= 32'h0000_0000;
      tx_busy_reg  <= 1'b0;
    end else if (tx_go && !(send_go && send_started_reg)) begin
      tx_shift_reg <= {1'b1, tx_data, 1'b0};
      tx_bits_reg  <= 4'(`BLS_FRAME_BITS);
      tx_cnt_reg   <= bit_cyc - 32'h0000_0001;
      tx_busy_reg  <= 1'b1;
    end else if (tx_busy_reg) begin
      if (tx_cnt_reg == 32'h0000_0000) begin
        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
        tx_bits_reg  <= tx_bits_reg - 4'h1;
        tx_cnt_reg   <= bit_cyc - 32'h0000_0001;
        tx_busy_reg  <= (tx_bits_reg != 4'h1);
      end else begin
        tx_cnt_reg <= tx_cnt_reg - 32'h0000_0001;
      end
    end
  end

  // Line driver and status
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      TX_LINE     <= 1'b1;
      BOOT_ACTIVE <= 1'b0;
    end else begin
      TX_LINE     <= (state_reg == ST_BRK) ? 1'b0 : (!tx_busy_reg || tx_shift_reg[0]); // RULE12
      BOOT_ACTIVE <= (state_reg != ST_IDLE) && (state_reg != ST_PWRUP);
    end
  end

  // Checksum: even bytes add low, odd bytes add high
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CK_SUM    <= 16'h0000;
      ck_hi_reg <= 1'b0;
    end else if (CK_IN.clear) begin
      CK_SUM    <= CK_IN.valid ? {8'h00, CK_IN.data} : 16'h0000;
      ck_hi_reg <= CK_IN.valid;
    end else if (CK_IN.valid) begin
      CK_SUM    <= ck_add(CK_SUM, ck_hi_reg ? {CK_IN.data, 8'h00} : {8'h00, CK_IN.data}); // RULE10
      ck_hi_reg <= !ck_hi_reg;
    end
  end

  sequence s_gap_done;
    (state_reg == ST_GAP) && (timer_reg == 32'h0000_0000);
  endsequence

  sequence s_frame_done;
    (state_reg == ST_SEND) && send_started_reg && !tx_busy_reg;
  endsequence

  AST_PWRUP_BOOT: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE1
    (state_reg == ST_PWRUP) && sw_closed |=> (state_reg == ST_WAIT) && (timer_reg == SETTLE))
    else $error("closed switch at power-up did not start the settle wait");
  AST_IDLE_TRIGGER: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE2
    (state_reg == ST_IDLE) && !sw_closed ##1 (state_reg == ST_IDLE) && sw_closed |=> (state_reg == ST_WAIT))
    else $error("open-close in idle did not start the settle wait");
  AST_SEEK_BEFORE_BREAK: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE3
    $rose(state_reg == ST_BRK) |-> $past(state_reg) == ST_SEEK && !$past(TAPE_SEEK_REQ))
    else $error("Break began without a finished seek");
  AST_DIGIT_GAP: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE5
    $rose(state_reg == ST_GAP) && is_digit |-> timer_reg == GAP_DIG)
    else $error("digit gap is not one character time");
  AST_CTRL_GAP: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE6
    $rose(state_reg == ST_GAP) && !is_digit |-> timer_reg == GAP_CTRL)
    else $error("control gap is not fifteen character times");
  AST_TERM_IDLE: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE7
    s_frame_done ##0 (char_reg == `BLS_CHAR_TERM) |=> (state_reg == ST_IDLE) ##1 !BOOT_ACTIVE)
    else $error("terminating character did not end boot");
  AST_NEXT_CHAR: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE4
    s_gap_done ##0 (char_reg != `BLS_CHAR_TERM) |=> (state_reg == ST_FETCH) && TAPE_CHAR_REQ)
    else $error("no fetch of the next character after the gap");
  AST_CONT_ONLY_CART: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE9
    cont_go |-> CART_PRESENT && (state_reg == ST_IDLE) ##1 tx_busy_reg && (tx_shift_reg[8:1] == `BLS_CHAR_CONT))
    else $error("Continue byte sent wrongly");
  AST_IGNORE_SWITCH: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE11
    (state_reg != ST_IDLE) |=> !saw_open_reg)
    else $error("switch activity remembered during boot");
  AST_BREAK_SPACE: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE12
    (state_reg == ST_BRK) [*2] |-> !TX_LINE)
    else $error("line not at space during Break");
  AST_CK_CLEAR: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RULE10
    CK_IN.clear && !CK_IN.valid |=> (CK_SUM == 16'h0000) && !ck_hi_reg)
    else $error("checksum not cleared");
endmodule : bls_boot_seq
`default_nettype wire

// ---- rtl/bls_defs.svh ----
// Timing counts, character codes and fixed figures of the boot sequencer
`ifndef BLS_DEFS_SVH
`define BLS_DEFS_SVH
`define BLS_CLK_HZ       250000000
`define BLS_SETTLE_MS    1000
`define BLS_SETTLE_CYC   (`BLS_CLK_HZ / 1000 * `BLS_SETTLE_MS)
`define BLS_BAUD_REF     9600
`define BLS_BIT_CYC      (`BLS_CLK_HZ / `BLS_BAUD_REF)
`define BLS_FRAME_BITS   10
`define BLS_ECHO_CHARS   15
`define BLS_BREAK_FRAMES 2
`define BLS_CHAR_TERM    8'h67
`define BLS_CHAR_CONT    8'h10
`define BLS_DIGIT_LO     8'h30
`define BLS_DIGIT_HI     8'h37
`endif

// ---- rtl/bls_pkg.sv ----
// Types shared by the boot sequencer
`default_nettype none
package bls_pkg;
  typedef enum logic [2:0] {
    ST_PWRUP = 3'h0,
    ST_IDLE  = 3'h1,
    ST_WAIT  = 3'h2,
    ST_SEEK  = 3'h3,
    ST_BRK   = 3'h4,
    ST_FETCH = 3'h5,
    ST_SEND  = 3'h6,
    ST_GAP   = 3'h7
  } bls_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } bls_char_t;

  typedef struct packed {
    logic       clear;
    logic       valid;
    logic [7:0] data;
  } bls_ck_t;
endpackage : bls_pkg
`default_nettype wire

// ---- rtl/bls_unused_placeholder_removed.sv ----
// Intentionally empty compilation unit
`default_nettype none
`default_nettype wire

// ---- verification/bls_far_model.sv ----
// Far-side model: tape drive 0 and the host serial receiver
`default_nettype none
module bls_far_model
  import bls_pkg::*;
#(
  parameter int unsigned BIT_CYC = 8
) (
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rst_n,
  // Tape drive 0
  input  wire logic      seek_req,
  output logic           seek_done,
  input  wire logic      char_req,
  output var bls_char_t  tape_char,
  // Serial line
  input  wire logic      tx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rom [4] = '{8'h30, 8'h37, 8'h38, 8'h67};
  logic [7:0] rx_q [$];
  int         rx_t [$];
  int         cyc, idx, dly, seek_t, brk_t, brk_len, rx_cnt, rx_bit, rx_t0;
  logic [7:0] rx_sh;
  logic       rx_busy = 1'b0;
  logic       rx_brk = 1'b0;
  int         bit_t = BIT_CYC;

  // Slow seek, characters alternately prompt and slow; data scrambles when not valid
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seek_done <= 1'b0;
      tape_char <= '0;
      dly       <= 0;
      cyc       <= 0;
    end else begin
      cyc             <= cyc + 1;
      seek_done       <= 1'b0;
      tape_char.valid <= 1'b0;
      tape_char.data  <= ~tape_char.data;
      if (seek_req && !seek_done) begin
        dly <= dly + 1;
        if (dly == 10) begin
          seek_done <= 1'b1;
          idx       <= 0;
          dly       <= 0;
          seek_t    <= cyc;
        end
      end else if (char_req && !tape_char.valid) begin
        dly <= dly + 1;
        if (dly == (idx[0] ? 4 : 0)) begin
          tape_char.valid <= 1'b1;
          tape_char.data  <= rom[idx % 4];
          idx             <= idx + 1;
          dly             <= 0;
        end
      end
    end
  end

  // Receiver bit time is set by the bench to the line rate in use; a low stop bit marks a Break
  always @(posedge clk) begin
    if (!rx_busy) begin
      if (tx_line === 1'b0) begin
        rx_busy = 1'b1;
        rx_cnt  = 0;
        rx_bit  = 0;
        rx_t0   = cyc;
      end
    end else begin
      rx_cnt = rx_cnt + 1;
      if (rx_cnt % bit_t == bit_t / 2) begin
        if (rx_bit >= 1 && rx_bit <= 8)
          rx_sh = {tx_line, rx_sh[7:1]};
        if (rx_bit == 9 && tx_line === 1'b1) begin
          rx_q.push_back(rx_sh);
          rx_t.push_back(rx_t0);
          rx_busy = 1'b0;
        end else if (rx_bit == 9)
          rx_brk = 1'b1;
        rx_bit = rx_bit + 1;
      end
      if (rx_brk && tx_line === 1'b1) begin
        brk_len = rx_cnt;
        brk_t   = rx_t0;
        rx_brk  = 1'b0;
        rx_busy = 1'b0;
      end
    end
  end
endmodule : bls_far_model
`default_nettype wire

// ---- verification/bls_boot_seq_tb.sv ----
// Self-checking bench of the boot sequencer
`default_nettype none
module bls_boot_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bls_pkg::*;
  localparam int unsigned SET = 50;
  localparam int unsigned BIT = 8;
  logic        clk = 1'b0, rst_n = 1'b0, pin = 1'b1, cart = 1'b0;
  logic        seek_req, seek_done, char_req, tx, active;
  logic [1:0]  baud = 2'h0;
  logic [15:0] ck_sum;
  bls_char_t   tape_char;
  bls_ck_t     ck_in = '0;
  int          err_count = 0, total_checks = 0;

  initial forever #2 clk = ~clk;

  bls_boot_seq #(.SETTLE_CYC(SET), .BIT_CYC(BIT)) i_bls_boot_seq (
    .CORE_CLK(clk), .RST_N(rst_n), .BOOT_SWITCH_PIN(pin), .BAUD_SEL(baud), .TX_LINE(tx),
    .CART_PRESENT(cart), .TAPE_SEEK_REQ(seek_req), .TAPE_SEEK_DONE(seek_done), .TAPE_CHAR_REQ(char_req),
    .TAPE_CHAR(tape_char), .BOOT_ACTIVE(active), .CK_IN(ck_in), .CK_SUM(ck_sum));
  bls_far_model #(.BIT_CYC(BIT)) i_bls_far_model (.clk(clk), .rst_n(rst_n), .seek_req(seek_req),
    .seek_done(seek_done), .char_req(char_req), .tape_char(tape_char), .tx_line(tx));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("Checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic do_reset(input logic p);
    @(negedge clk);
    rst_n = 1'b0;
    pin = p;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
  endtask : do_reset

  // Full boot: settle, seek, Break, paced stream, exit; switch bounced mid-boot
  task automatic run_boot(input int fb);
    int n, t, d, e;
    n = 0;
    while (seek_req !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check("settle", 16'(n >= SET && n <= SET + 6), 16'h1);
    check("boot_active", {15'h0, active}, 16'h1);
    i_bls_far_model.rx_q.delete();
    i_bls_far_model.rx_t.delete();
    i_bls_far_model.brk_len = 0;
    i_bls_far_model.brk_t = 0;
    pin = 1'b1;
    repeat (3) @(negedge clk);
    pin = 1'b0;
    n = 0;
    while (active !== 1'b0 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    check("boot_end", {15'h0, active}, 16'h0);
    t = i_bls_far_model.cyc;
    check("rx_count", 16'(i_bls_far_model.rx_q.size()), 16'h4);
    if (i_bls_far_model.rx_q.size() == 4) begin
      for (int i = 0; i < 4; i++)
        check("rx_char", {8'h0, i_bls_far_model.rx_q[i]}, {8'h0, i_bls_far_model.rom[i]});
      for (int i = 0; i < 3; i++) begin
        d = i_bls_far_model.rx_t[i + 1] - i_bls_far_model.rx_t[i];
        e = 10 * fb + BIT * ((i_bls_far_model.rom[i] inside {[8'h30:8'h37]}) ? 10 : 150);
        check("gap", 16'(d >= e && d <= e + 24), 16'h1);
      end
      check("term_exit", 16'(t - i_bls_far_model.rx_t[3] <= 10 * fb + 8), 16'h1);
    end
    check("break_len", 16'(i_bls_far_model.brk_len > 10 * fb), 16'h1);
    check("seek_first", 16'(i_bls_far_model.brk_t > i_bls_far_model.seek_t), 16'h1);
    repeat (SET + 20) @(negedge clk);
    check("no_reboot", {15'h0, active}, 16'h0);
  endtask : run_boot

  task automatic t_continue;
    int n;
    i_bls_far_model.rx_q.delete();
    cart = 1'b1;
    n = 0;
    while (i_bls_far_model.rx_q.size() == 0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check("continue", {8'h0, i_bls_far_model.rx_q[0]}, 16'h0010);
    repeat (300) @(negedge clk);
    check("continue_once", 16'(i_bls_far_model.rx_q.size()), 16'h1);
  endtask : t_continue

  // Includes a pair that carries out of bit 15
  task automatic t_checksum;
    logic [7:0] b [6] = '{8'h01, 8'h0A, 8'hFF, 8'hFF, 8'h03, 8'h80};
    int acc;
    acc = 0;
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      ck_in.clear = (i == 0);
      ck_in.valid = 1'b1;
      ck_in.data = b[i];
      acc = acc + (i % 2 ? int'(b[i]) << 8 : int'(b[i]));
      if (acc > 'hFFFF) acc = acc - 'hFFFF;
      @(negedge clk);
      ck_in = '0;
      check("ck_sum", ck_sum, 16'(acc));
    end
  endtask : t_checksum

  initial begin
    do_reset(1'b1);
    repeat (100) @(negedge clk);
    check("no_boot_open", {15'h0, active}, 16'h0);
    do_reset(1'b0);
    run_boot(BIT);
    pin = 1'b1;
    repeat (2) @(negedge clk);
    pin = 1'b0;
    run_boot(BIT);
    // Line at 38400: frames shrink, pacing gaps keep the 9600 timing
    baud = 2'h2;
    i_bls_far_model.bit_t = BIT / 4;
    pin = 1'b1;
    repeat (2) @(negedge clk);
    pin = 1'b0;
    run_boot(BIT / 4);
    t_continue();
    t_checksum();
    complete_run();
  end

  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule : bls_boot_seq_tb
`default_nettype wire
